// ### core/ropc_output_ctrl.sv
`timescale 1ns/1ps
`include "ropc_cfg.svh"
// Notes on behaviour
// R1: Route offset write sends packet route bytes.
// R2: Transaction offset write sends one transaction.
// R3: End offset write sends end-of-packet marker.
// R4: Software orders route, transactions, then end.
// R5: Space reads return buffer pointer low bits.
// R6: Top bit set when two transactions fit.
// R7: Status top bit set once packet ended.
// R8: Reply codes zero, ack one, nack five.
// R9: Timeout reports top bit with code four.
// R10: Clear write drops reply, frees logic.
// R11: Software clears reply after reading status.
// R12: Reserve write allocates one buffer slot.
// R13: Slot pointer write keeps only bits three-one.
// R14: Valid offset read shows buffer valid flag.
// R15: Status register is readable and writable.
// R16: Read-only writes ignored; write-only reads zero.
module ropc_output_ctrl #(
	parameter int DEPTH = 16,
	parameter int TIMEOUT_CYCLES = `ROPC_REPLY_TIMEOUT_US * `ROPC_CLK_MHZ
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Register port.
	input wire ropc_pkg::ropc_req_t req,
	output logic [31:0] rdata,
	// Link toward the network.
	output ropc_pkg::ropc_link_t link,
	// Transactions leaving the output buffer.
	input wire logic trans_done,
	// Reply from the remote processor (pin level).
	input wire logic reply_in,
	input wire logic reply_nack_in,
	// Reply buffer state.
	input wire logic slot_fill,
	// Interrupt.
	output logic irq
);
	import ropc_pkg::*;

	localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
	localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

	// Refused at elaboration: the pointer is eight bits wide and the count nine.
	if (DEPTH < 2 || DEPTH > 256 || TIMEOUT_CYCLES < 1) begin : g_bad_size
		$error("ropc_output_ctrl: unsupported DEPTH or TIMEOUT_CYCLES");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Decode helpers.

	// One-cycle write hit at a given offset.
	function automatic logic wr_hit(input ropc_req_t r, input logic [7:0] off);
		wr_hit = r.wr && (r.addr == off);
	endfunction

	logic go_route;
	logic go_trans;
	logic go_end;
	logic go_clear;
	logic go_reserve;
	assign go_route = wr_hit(req, `ROPC_OFF_ROUTE);
	assign go_trans = wr_hit(req, `ROPC_OFF_TRANS);
	assign go_end = wr_hit(req, `ROPC_OFF_END);
	assign go_clear = wr_hit(req, `ROPC_OFF_REPLY_CLR);
	assign go_reserve = wr_hit(req, `ROPC_OFF_RESERVE);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: the reply and fill levels come from outside this clock.

	logic [2:0] sync_a;
	logic [2:0] sync_b;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {slot_fill, reply_nack_in, reply_in};
			sync_b <= sync_a;
		end
	end
	logic reply_s;
	logic nack_s;
	logic fill_s;
	assign reply_s = sync_b[0];
	assign nack_s = sync_b[1];
	assign fill_s = sync_b[2];

	////////////////////////////////////////////////////////////////////////////////
	// Output buffer occupancy: reserve takes a slot, a sent transaction frees it.

	logic [7:0] space_ptr;
	logic [8:0] used;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			space_ptr <= `ROPC_RST_SPACE;
			used <= 9'h000;
		end else begin
			if (go_reserve && used < 9'(DEPTH)) begin // [R12]
				space_ptr <= (space_ptr == 8'(DEPTH - 1)) ? 8'h00 : space_ptr + 8'h01;
			end
			// Reserve and drain in one cycle cancel out.
			case ({go_reserve && used < 9'(DEPTH), trans_done && used != 9'h000})
				2'b10: used <= used + 9'h001; // [R12]
				2'b01: used <= used - 9'h001;
				default: used <= used;
			endcase
		end
	end
	logic room_two;
	assign room_two = (9'(DEPTH) - used) >= 9'h002; // [R6]

	////////////////////////////////////////////////////////////////////////////////
	// Packet sequencing and link symbols.

	typedef enum logic [1:0] {ST_IDLE, ST_BODY, ST_WAIT, ST_DONE} ropc_state_t;
	ropc_state_t state;
	logic [31:0] reply_code;
	logic [TO_W-1:0] wait_cnt;
	logic ev_reply;

	// Symbols go out one cycle after the trigger write; no stall is needed
	// because the link accepts one symbol per clock.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link <= '0;
		end else begin
			link.valid <= go_route || go_trans || go_end; // [R1] [R2] [R3]
			link.slot <= space_ptr;
			if (go_route) begin
				link.sym <= ROPC_SYM_ROUTE; // [R1]
			end else if (go_trans) begin
				link.sym <= ROPC_SYM_TRANS; // [R2]
			end else begin
				link.sym <= ROPC_SYM_END; // [R3]
			end
		end
	end

	// Out-of-order triggers (R4 on software) are still sent; the state only
	// tracks when the reply wait begins.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			reply_code <= `ROPC_REPLY_NONE;
			wait_cnt <= '0;
			ev_reply <= 1'b0;
		end else begin
			ev_reply <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (go_route) begin
						state <= ST_BODY;
					end
				end
				ST_BODY: begin
					if (go_end) begin
						state <= ST_WAIT; // [R3]
						wait_cnt <= '0;
					end
				end
				ST_WAIT: begin
					if (go_clear) begin
						state <= ST_IDLE; // [R10]
					end else if (reply_s) begin
						state <= ST_DONE;
						ev_reply <= 1'b1;
						reply_code <= nack_s ? `ROPC_REPLY_NACK : `ROPC_REPLY_ACK; // [R7] [R8]
					end else if (wait_cnt == TO_LAST) begin
						state <= ST_DONE;
						ev_reply <= 1'b1;
						reply_code <= `ROPC_REPLY_TIMEOUT; // [R9]
					end else begin
						wait_cnt <= wait_cnt + TO_W'(1);
					end
				end
				ST_DONE: begin
					if (go_clear) begin
						state <= ST_IDLE; // [R10]
						reply_code <= `ROPC_REPLY_NONE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Software registers.

	logic [3:1] slot_ptr;
	logic [31:0] proc_status;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	// Plain storage for software; the slot pointer keeps only its three bits.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			slot_ptr <= 3'h0;
			proc_status <= `ROPC_RST_STATUS;
			irq_mask <= 2'h0;
		end else begin
			if (wr_hit(req, `ROPC_OFF_SLOT_PTR)) begin
				slot_ptr <= req.wdata[`ROPC_PTR_HI:`ROPC_PTR_LO]; // [R13]
			end
			if (wr_hit(req, `ROPC_OFF_STATUS)) begin
				proc_status <= req.wdata; // [R15]
			end
			if (wr_hit(req, `ROPC_OFF_IRQ_MASK)) begin
				irq_mask <= req.wdata[1:0];
			end
		end
	end

	// Bit 0: reply or timeout held; bit 1: room for two came back. Set wins.
	logic room_prev;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_stat <= 2'h0;
			room_prev <= 1'b1;
		end else begin
			room_prev <= room_two;
			for (int i = 0; i < 2; i++) begin
				if (wr_hit(req, `ROPC_OFF_IRQ_STAT) && req.wdata[i]) begin
					irq_stat[i] <= 1'b0;
				end
			end
			if (ev_reply) begin
				irq_stat[0] <= 1'b1;
			end
			if (room_two && !room_prev) begin
				irq_stat[1] <= 1'b1;
			end
		end
	end

	// Registered so the pin cannot glitch while status and mask change together.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, valid only in the cycle after the read strobe.

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata <= 32'h00000000;
		end else if (req.rd) begin
			case (req.addr)
				`ROPC_OFF_ROUTE, `ROPC_OFF_TRANS: begin
					rdata <= {room_two, 23'h000000, space_ptr}; // [R5] [R6]
				end
				`ROPC_OFF_REPLY_STAT: rdata <= reply_code; // [R8]
				`ROPC_OFF_SLOT_PTR: rdata <= {28'h0000000, slot_ptr, 1'b0};
				`ROPC_OFF_SLOT_VALID: rdata <= {fill_s, 31'h00000000}; // [R14]
				`ROPC_OFF_STATUS: rdata <= proc_status; // [R15]
				`ROPC_OFF_IRQ_STAT: rdata <= {30'h00000000, irq_stat};
				`ROPC_OFF_IRQ_MASK: rdata <= {30'h00000000, irq_mask};
				default: rdata <= 32'h00000000; // [R16]
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_end_sent;
		go_end && state == ST_BODY;
	endsequence

	a_route_symbol: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
		go_route |=> link.valid && link.sym == ROPC_SYM_ROUTE)
		else $error("route write did not send route symbol");
	a_trans_symbol: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		go_trans && !go_route |=> link.valid && link.sym == ROPC_SYM_TRANS)
		else $error("transaction write did not send transaction");
	a_end_symbol: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
		s_end_sent |=> link.valid && link.sym == ROPC_SYM_END && state == ST_WAIT)
		else $error("end write did not send end marker");
	a_space_read: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		req.rd && req.addr == `ROPC_OFF_ROUTE |=> rdata[7:0] == $past(space_ptr))
		else $error("space read lost pointer");
	a_room_bit: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
		req.rd && req.addr == `ROPC_OFF_TRANS |=> rdata[31] == $past(room_two))
		else $error("room bit wrong");
	a_reply_code: assert property (@(posedge clk) disable iff (sys_rst) // [R7] [R8]
		state == ST_WAIT && !go_clear && reply_s && !nack_s |=> reply_code == 32'h80000001)
		else $error("ack code wrong");
	a_timeout_code: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
		state == ST_WAIT && !go_clear && !reply_s && wait_cnt == TO_LAST
		|=> reply_code == 32'h80000004)
		else $error("timeout code wrong");
	a_clear_frees: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
		go_clear && state == ST_DONE |=> state == ST_IDLE && reply_code == 32'h0)
		else $error("clear did not free reply logic");
	a_reserve_count: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
		go_reserve && !trans_done && used < 9'(DEPTH) |=> used == $past(used) + 9'h001)
		else $error("reserve did not take a slot");
	a_ptr_bits: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
		wr_hit(req, `ROPC_OFF_SLOT_PTR) |=> slot_ptr == $past(req.wdata[3:1]))
		else $error("pointer write wrong bits");
	a_wo_reads_zero: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
		req.rd && req.addr == `ROPC_OFF_END |=> rdata == 32'h0)
		else $error("write-only read not zero");

	////////////////////////////////////////////////////////////////////////////////
	// Further checks: reply outcome, registers, buffer accounting and link symbols.

	sequence s_nack_seen;
		state == ST_WAIT && !go_clear && reply_s && nack_s;
	endsequence

	// A negative answer must land as code five with the ended bit.
	a_nack_code: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
		s_nack_seen |=> reply_code == 32'h80000005)
		else $error("nack code wrong");

	// Until an outcome is held, software must read all zeros.
	a_reply_none: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
		state != ST_DONE |-> reply_code == 32'h00000000)
		else $error("reply code set before outcome");

	// Once an outcome is held, the ended bit stays up until the clear.
	a_reply_held: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
		state == ST_DONE |-> reply_code[31])
		else $error("ended bit missing while outcome held");

	// A write to the status read offset must leave the held outcome alone.
	a_status_ro: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
		req.wr && req.addr == `ROPC_OFF_REPLY_STAT && state != ST_WAIT
		|=> reply_code == $past(reply_code))
		else $error("write changed reply status");

	// The valid flag read shows the synchronised fill level in the top bit.
	a_valid_read: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
		req.rd && req.addr == `ROPC_OFF_SLOT_VALID
		|=> rdata == {$past(fill_s), 31'h00000000})
		else $error("valid flag read wrong");

	// The status word keeps every written bit.
	a_status_rw: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
		wr_hit(req, `ROPC_OFF_STATUS) |=> proc_status == $past(req.wdata))
		else $error("status write lost");

	// The status word reads back as stored.
	a_status_read: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
		req.rd && req.addr == `ROPC_OFF_STATUS |=> rdata == $past(proc_status))
		else $error("status read wrong");

	// The slot pointer reads back in its own bits with the rest zero.
	a_slot_read: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
		req.rd && req.addr == `ROPC_OFF_SLOT_PTR
		|=> rdata == {28'h0000000, $past(slot_ptr), 1'b0})
		else $error("slot pointer read wrong");

	// A full buffer must refuse a reserve without moving the pointer.
	a_reserve_full: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
		go_reserve && !trans_done && used == 9'(DEPTH)
		|=> used == $past(used) && space_ptr == $past(space_ptr))
		else $error("reserve taken while full");

	// A drained transaction frees one slot unless a reserve lands in the same cycle or no slot is taken.
	a_drain_frees: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
		trans_done && !go_reserve && used != 9'h000 |=> used == $past(used) - 9'h001)
		else $error("drain did not free a slot");

	// Each symbol carries the pointer that stood at its trigger write.
	a_symbol_slot: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		go_route || go_trans || go_end |=> link.slot == $past(space_ptr))
		else $error("symbol carries wrong slot");

	// With no trigger the link stays quiet, so one write sends one symbol.
	a_link_quiet: assert property (@(posedge clk) disable iff (sys_rst) // [R1] [R2] [R3]
		!(go_route || go_trans || go_end) |=> !link.valid)
		else $error("symbol sent without a trigger");
endmodule

// ### core/ropc_cfg.svh
`ifndef ROPC_CFG_SVH
`define ROPC_CFG_SVH
// Register offsets on the plain register port, one byte wide.
`define ROPC_OFF_ROUTE 8'h80
`define ROPC_OFF_TRANS 8'h81
`define ROPC_OFF_END 8'h82
`define ROPC_OFF_REPLY_STAT 8'h83
`define ROPC_OFF_REPLY_CLR 8'h84
`define ROPC_OFF_RESERVE 8'h85
`define ROPC_OFF_SLOT_PTR 8'h88
`define ROPC_OFF_SLOT_VALID 8'h8B
`define ROPC_OFF_STATUS 8'h8F
`define ROPC_OFF_IRQ_STAT 8'h90
`define ROPC_OFF_IRQ_MASK 8'h91
// Field positions.
`define ROPC_TOP_BIT 31
`define ROPC_PTR_LO 1
`define ROPC_PTR_HI 3
// Reply status read values.
`define ROPC_REPLY_NONE 32'h00000000
`define ROPC_REPLY_ACK 32'h80000001
`define ROPC_REPLY_TIMEOUT 32'h80000004
`define ROPC_REPLY_NACK 32'h80000005
// Reset values.
`define ROPC_RST_STATUS 32'h00000000
`define ROPC_RST_SPACE 8'h00
// Reply wait limit.
`define ROPC_REPLY_TIMEOUT_US 100
`define ROPC_CLK_MHZ 125
`endif

// ### core/ropc_pkg.sv
package ropc_pkg;
	// Reply outcome reported by the far end.
	typedef enum logic [1:0] {ROPC_RPL_ACK, ROPC_RPL_NACK} ropc_reply_t;
	// Register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} ropc_req_t;
	// Link symbol sent to the network.
	typedef enum logic [1:0] {ROPC_SYM_ROUTE, ROPC_SYM_TRANS, ROPC_SYM_END} ropc_sym_t;
	typedef struct packed {
		logic valid;
		ropc_sym_t sym;
		logic [7:0] slot;
	} ropc_link_t;
endpackage

// ### bench/ropc_far_end.sv
`timescale 1ns/1ps
// Remote end of the link: drains sent transactions and answers each closed packet unless silent is set.
module ropc_far_end (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Link from the block and lines back to it.
	input wire ropc_pkg::ropc_link_t link,
	output logic trans_done,
	output logic reply_in,
	output logic reply_nack_in,
	// Scenario controls: slow answers, no answer at all, negative answer.
	input wire logic slow,
	input wire logic silent,
	input wire logic nack
);
	import ropc_pkg::*;
	int pend;
	int gap;
	int rep_cnt;
	logic act;
	assign act = (rep_cnt >= 1) && (rep_cnt <= 4);
	// One drain pulse per queued transaction, spaced out so the buffer really fills.
	always_ff @(posedge clk) begin
		trans_done <= 1'b0;
		if (sys_rst) begin
			pend <= 0;
			gap <= 0;
		end else begin
			if (gap > 0) begin
				gap <= gap - 1;
			end else if (pend > 0) begin
				trans_done <= 1'b1;
				gap <= slow ? 12 : 2;
			end
			pend <= pend + int'(link.valid && link.sym == ROPC_SYM_TRANS)
				- int'(gap == 0 && pend > 0);
		end
	end
	// The reply is a short level; between replies the kind line toggles, since nobody drives it.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rep_cnt <= 0;
			reply_in <= 1'b0;
			reply_nack_in <= 1'b1;
		end else begin
			if (link.valid && link.sym == ROPC_SYM_END && !silent) begin
				rep_cnt <= slow ? 12 : 5;
			end else if (rep_cnt > 0) begin
				rep_cnt <= rep_cnt - 1;
			end
			reply_in <= act;
			reply_nack_in <= act ? nack : ~reply_nack_in;
		end
	end
endmodule

// ### bench/reply_output_packet_control_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin error_cnt++; \
	$display("BAD %s exp %h got %h", nm, ex, gt); end end
module reply_output_packet_control_test;
	import ropc_pkg::*;
	localparam int D = 4;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	ropc_req_t req = '0;
	logic [31:0] rdata;
	ropc_link_t link;
	logic trans_done, reply_in, reply_nack_in, irq;
	logic slot_fill = 1'b0;
	logic slow = 1'b0;
	logic silent = 1'b0;
	logic nack = 1'b0;
	int error_cnt = 0;
	int n_compared = 0;
	int ptr = 0;
	int occ = 0;
	int m;
	logic [31:0] rnd = 32'h59;
	logic [31:0] v, e;
	logic [9:0] exp_q[$];
	logic [9:0] got_q[$];
	logic [7:0] za[6] = '{8'h82, 8'h84, 8'h85, 8'h83, 8'h8B, 8'h9F};
	ropc_output_ctrl #(.DEPTH(D), .TIMEOUT_CYCLES(20)) ropc_output_ctrl_inst (.clk(clk),
		.sys_rst(sys_rst), .req(req), .rdata(rdata), .link(link), .trans_done(trans_done),
		.reply_in(reply_in), .reply_nack_in(reply_nack_in), .slot_fill(slot_fill), .irq(irq));
	ropc_far_end ropc_far_end_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
		.trans_done(trans_done), .reply_in(reply_in), .reply_nack_in(reply_nack_in),
		.slow(slow), .silent(silent), .nack(nack));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		rnd ^= rnd << 13;
		rnd ^= rnd >> 17;
		rnd ^= rnd << 5;
		return rnd;
	endfunction
	// Expected space read: pointer low, top bit while two more transactions fit.
	function automatic logic [31:0] space();
		return {(D - occ >= 2), 23'h0, ptr[7:0]};
	endfunction
	// One strobe cycle; read data are caught in the single cycle they stand.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		#1 v = rdata;
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
		bus(1'b0, a, 32'h0);
		`CHK(nm, ex, v)
	endtask
	task automatic irq_chk(input logic ex, input string nm);
		@(negedge clk);
		`CHK(nm, ex, irq)
		@(posedge clk);
	endtask
	task automatic trig(input logic [7:0] a, input ropc_sym_t s);
		exp_q.push_back({s, ptr[7:0]});
		bus(1'b1, a, xs());
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Free-running clock.
	initial begin
		forever #4 clk = ~clk;
	end
	// Every symbol the block puts on the link, in order.
	always @(posedge clk) begin
		if (!sys_rst && link.valid === 1'b1) begin
			got_q.push_back({link.sym, link.slot});
		end
	end
	// A hang costs a mismatch; the run is far shorter than this.
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rd_chk(8'h8F, 32'h0, "status rst");
		rd_chk(8'h80, 32'h80000000, "word space");
		rd_chk(8'h83, 32'h0, "reply idle");
		for (m = 0; m < 4; m++) begin
			e = xs();
			bus(1'b1, 8'h8F, e);
			rd_chk(8'h8F, e, "status rw");
			bus(1'b1, 8'h88, ~e);
			rd_chk(8'h88, {28'h0, ~e[3:1], 1'b0}, "slot ptr");
		end
		bus(1'b1, 8'h83, 32'hFFFFFFFF);
		bus(1'b1, 8'h8B, 32'hFFFFFFFF);
		foreach (za[i]) rd_chk(za[i], 32'h0, "zero read");
		slot_fill <= 1'b1;
		repeat (3) @(posedge clk);
		rd_chk(8'h8B, 32'h80000000, "slot valid");
		$display("test registers done");
		// Fill the buffer one past full; the last reserve must be ignored.
		for (m = 0; m <= D; m++) begin
			bus(1'b1, 8'h85, xs());
			if (occ < D) begin
				occ++;
				ptr = (ptr + 1) % D;
			end
			rd_chk(8'h81, space(), "byte space");
		end
		$display("test reserve done");
		bus(1'b1, 8'h91, 32'h1);
		// Packets answered by ack, slow nack and no answer.
		for (m = 0; m < 3; m++) begin
			slow <= (m == 1);
			silent <= (m == 2);
			nack <= (m == 1);
			if (m > 0) begin
				bus(1'b1, 8'h85, 32'h0);
				occ++;
				ptr = (ptr + 1) % D;
			end
			trig(8'h80, ROPC_SYM_ROUTE);
			repeat ((m == 0) ? D : 1) trig(8'h81, ROPC_SYM_TRANS);
			trig(8'h82, ROPC_SYM_END);
			occ -= (m == 0) ? D : 1;
			rd_chk(8'h83, 32'h0, "reply wait");
			repeat (40) @(posedge clk);
			e = (m == 0) ? 32'h80000001 : (m == 1) ? 32'h80000005 : 32'h80000004;
			rd_chk(8'h83, e, "reply code");
			irq_chk(1'b1, "irq set");
			rd_chk(8'h90, 32'h3, "irq stat");
			bus(1'b1, 8'h91, 32'h0);
			irq_chk(1'b0, "irq masked");
			bus(1'b1, 8'h91, 32'h1);
			bus(1'b1, 8'h90, 32'h1);
			bus(1'b1, 8'h84, 32'h0);
			irq_chk(1'b0, "irq clear");
			rd_chk(8'h83, 32'h0, "reply clear");
			rd_chk(8'h80, space(), "word space");
		end
		`CHK("link count", exp_q.size(), got_q.size())
		foreach (exp_q[i]) `CHK("link symbol", exp_q[i], got_q[i])
		$display("test packets done");
		summarize();
	end
endmodule
